// ---- include/pwc_map.svh ----
// Purpose: offsets, field positions, reset values and responses of the wake-up counter
// Assumes: 32-bit register words, one word per register
// Notes:   definitions only
// Function
// RQ1: set the match flag, bit 7, when the counter reaches the modulo value.
// RQ2: writing one to the flag clears it and its request; zero leaves it.
// RQ3: reset clears flag, source select, interrupt enable and divider select.
// RQ4: source field bits 6-5: 00 low-power osc, 01 external, 1x internal reference.
// RQ5: a changed source selection clears prescaler and counter.
// RQ6: with enable bit 4 set, a set flag raises the request; else polling.
// RQ7: source low bit zero: codes give off,8,32,64,128,256,512,1024,1,2,4,10,16,100,500,1000.
// RQ8: source low bit one: off,1024..65536 binary, then 1000..200000 decimal ratios.
// RQ9: writing a different divider select clears prescaler and counter.
// RQ10: count register reads the live eight-bit count and ignores writes.
// RQ11: reset clears the counter to zero.
// RQ12: on a match the counter reloads zero and the flag sets.
// RQ13: modulo zero sets the flag on every prescaler output event.
// RQ14: any write to the modulo register clears prescaler and counter; here only writes with byte lane 0 enabled do.
// RQ15: reset loads the modulo register with zero.
// RQ16: no off-chip pins; all inputs and outputs are internal.
// RQ17: software enables the selected source clock before relying on the counter.
// RQ18: eight-bit counter and modulo; exactly three registers.
// RQ19: counter advances per prescaler event up to the modulo, wraps, continues.
// RQ20: flag sets on the step from modulo value to zero.
// RQ21: reset leaves prescaler off and low-power source; nonzero divider starts counting.
// RQ22: debug halt freezes counting; counting resumes from the held value.
// RQ23: interrupt request is flag AND enable, held until the flag clears.
// RQ24: source clock edges are synchronised into the bus clock before use.
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH
`define PWC_OFS_STATUS  12'h000
`define PWC_OFS_COUNT   12'h004
`define PWC_OFS_MODULO  12'h008
`define PWC_BIT_FLAG    7
`define PWC_BIT_IE      4
`define PWC_CTRL_RESET  8'h00
`define PWC_CNT_RESET   8'h00
`define PWC_MOD_RESET   8'h00
`define PWC_PS_RESET    18'h00000
`define PWC_RESP_OKAY   2'h0
`define PWC_RESP_DECERR 2'h3
`define PWC_SRC_LPO     2'h0
`define PWC_SRC_EXT     2'h1
`endif

// ---- include/pwc_pkg.sv ----
// Purpose: types shared by the wake-up counter
// Assumes: constants live in pwc_map.svh
// Notes:   control byte layout matches the status/control register
package pwc_pkg;
  typedef struct packed {
    logic       flag;
    logic [1:0] src;
    logic       ie;
    logic [3:0] ps;
  } ctrl_s;
  typedef logic [17:0] ratio_t;
  typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_e;
  typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_e;
  typedef enum logic [1:0] {
    REG_STATUS = 2'b00,
    REG_COUNT  = 2'b01,
    REG_MODULO = 2'b10,
    REG_NONE   = 2'b11
  } reg_sel_e;
endpackage : pwc_pkg

// ---- verilog/periodic_wakeup_counter.sv ----
// Purpose: periodic wake-up counter with selectable source, prescaler and modulo match
// Assumes: source clocks run well below clk/4; all logic on clk
// Notes:   registers over AXI4-Lite, unmapped addresses answer DECERR
`timescale 1ns/1ps
`include "pwc_map.svh"
module periodic_wakeup_counter #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              lowPowerOscClk,
  input  wire logic              externalRefClk,
  input  wire logic              internalRefClk,
  input  wire logic              debugHalt,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   matchIrq  // internal request line, no off-chip pin [RQ16]
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // divide ratio per source low bit and divider code; zero means off
  function automatic pwc_pkg::ratio_t divRatio(input logic srcLow, input logic [3:0] ps);
    pwc_pkg::ratio_t r;
    r = 18'h00000;
    case ({srcLow, ps})
      5'h01:   r = 18'h00008; // [RQ7]
      5'h02:   r = 18'h00020;
      5'h03:   r = 18'h00040;
      5'h04:   r = 18'h00080;
      5'h05:   r = 18'h00100;
      5'h06:   r = 18'h00200;
      5'h07:   r = 18'h00400;
      5'h08:   r = 18'h00001;
      5'h09:   r = 18'h00002;
      5'h0a:   r = 18'h00004;
      5'h0b:   r = 18'h0000a;
      5'h0c:   r = 18'h00010;
      5'h0d:   r = 18'h00064;
      5'h0e:   r = 18'h001f4;
      5'h0f:   r = 18'h003e8;
      5'h11:   r = 18'h00400; // [RQ8]
      5'h12:   r = 18'h00800;
      5'h13:   r = 18'h01000;
      5'h14:   r = 18'h02000;
      5'h15:   r = 18'h04000;
      5'h16:   r = 18'h08000;
      5'h17:   r = 18'h10000;
      5'h18:   r = 18'h003e8;
      5'h19:   r = 18'h007d0;
      5'h1a:   r = 18'h01388;
      5'h1b:   r = 18'h02710;
      5'h1c:   r = 18'h04e20;
      5'h1d:   r = 18'h0c350;
      5'h1e:   r = 18'h186a0;
      5'h1f:   r = 18'h30d40;
      default: r = 18'h00000; // off
    endcase
    return r;
  endfunction : divRatio

  // word decode shared by the read and write paths
  function automatic pwc_pkg::reg_sel_e regSel(input logic [ADDR_W-1:0] a);
    pwc_pkg::reg_sel_e s;
    s = pwc_pkg::REG_NONE;
    if (a[11:2] == `PWC_OFS_STATUS >> 2) s = pwc_pkg::REG_STATUS;
    else if (a[11:2] == `PWC_OFS_COUNT >> 2) s = pwc_pkg::REG_COUNT; // [RQ18]
    else if (a[11:2] == `PWC_OFS_MODULO >> 2) s = pwc_pkg::REG_MODULO;
    return s;
  endfunction : regSel

  ////////////////////////////////////////////////////////////////////////////
  // source synchronisers

  logic [2:0] srcIn;
  logic [2:0] srcMeta_r;
  logic [2:0] srcSync_r;
  logic [2:0] srcPrev_r;
  logic [2:0] srcRise;

  assign srcIn = {internalRefClk, externalRefClk, lowPowerOscClk};

  // two flops per source, then an edge detector on the second stage only
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          srcMeta_r[gi] <= 1'b0;
          srcSync_r[gi] <= 1'b0;
          srcPrev_r[gi] <= 1'b0;
        end else begin
          srcMeta_r[gi] <= srcIn[gi];     // [RQ24]
          srcSync_r[gi] <= srcMeta_r[gi];
          srcPrev_r[gi] <= srcSync_r[gi];
        end
      end
      assign srcRise[gi] = srcSync_r[gi] & ~srcPrev_r[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register state

  pwc_pkg::ctrl_s  ctrl_r;
  pwc_pkg::ctrl_s  ctrl_nxt;
  logic [7:0]      cnt_r;
  logic [7:0]      cnt_nxt;
  logic [7:0]      mod_r;
  logic [7:0]      mod_nxt;
  pwc_pkg::ratio_t psCnt_r;
  pwc_pkg::ratio_t psCnt_nxt;
  logic            irq_r;
  logic            irq_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel state

  pwc_pkg::wr_state_e wrState_r;
  pwc_pkg::wr_state_e wrState_nxt;
  logic               awHeld_r;
  logic               awHeld_nxt;
  logic [ADDR_W-1:0]  awAddr_r;
  logic [ADDR_W-1:0]  awAddr_nxt;
  logic               wHeld_r;
  logic               wHeld_nxt;
  logic [7:0]         wByte_r;
  logic [7:0]         wByte_nxt;
  logic               wLane_r;
  logic               wLane_nxt;
  logic               awready_r;
  logic               awready_nxt;
  logic               wready_r;
  logic               wready_nxt;
  logic               bvalid_r;
  logic               bvalid_nxt;
  logic [1:0]         bresp_r;
  logic [1:0]         bresp_nxt;
  logic               awTake;
  logic               wTake;
  logic               doWrite;
  logic [ADDR_W-1:0]  wrAddr;
  logic [7:0]         wrByte;
  logic               wrLane;
  pwc_pkg::reg_sel_e  wrSel;

  // address and data are taken independently; the write lands when both are in
  always_comb begin
    awTake      = awvalid & awready_r;
    wTake       = wvalid & wready_r;
    wrAddr      = awHeld_r ? awAddr_r : awaddr;
    wrByte      = wHeld_r ? wByte_r : wdata[7:0];
    wrLane      = wHeld_r ? wLane_r : wstrb[0];
    wrSel       = regSel(wrAddr);
    doWrite     = (wrState_r == pwc_pkg::WR_IDLE) & (awHeld_r | awTake) & (wHeld_r | wTake);
    wrState_nxt = wrState_r;
    awHeld_nxt  = awHeld_r | awTake;
    awAddr_nxt  = awTake ? awaddr : awAddr_r;
    wHeld_nxt   = wHeld_r | wTake;
    wByte_nxt   = wTake ? wdata[7:0] : wByte_r;
    wLane_nxt   = wTake ? wstrb[0] : wLane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    awready_nxt = awready_r & ~awTake;
    wready_nxt  = wready_r & ~wTake;
    case (wrState_r)
      pwc_pkg::WR_IDLE: begin
        if (doWrite) begin
          wrState_nxt = pwc_pkg::WR_RESP;
          awHeld_nxt  = 1'b0;
          wHeld_nxt   = 1'b0;
          awready_nxt = 1'b0;
          wready_nxt  = 1'b0;
          bvalid_nxt  = 1'b1;
          bresp_nxt   = (wrSel == pwc_pkg::REG_NONE) ? `PWC_RESP_DECERR : `PWC_RESP_OKAY;
        end
      end
      pwc_pkg::WR_RESP: begin
        if (bready) begin
          wrState_nxt = pwc_pkg::WR_IDLE;
          bvalid_nxt  = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt  = 1'b1;
        end
      end
      default: wrState_nxt = pwc_pkg::WR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrState_r <= pwc_pkg::WR_IDLE;
      awHeld_r  <= 1'b0;
      awAddr_r  <= '0;
      wHeld_r   <= 1'b0;
      wByte_r   <= 8'h00;
      wLane_r   <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PWC_RESP_OKAY;
    end else begin
      wrState_r <= wrState_nxt;
      awHeld_r  <= awHeld_nxt;
      awAddr_r  <= awAddr_nxt;
      wHeld_r   <= wHeld_nxt;
      wByte_r   <= wByte_nxt;
      wLane_r   <= wLane_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel

  pwc_pkg::rd_state_e rdState_r;
  pwc_pkg::rd_state_e rdState_nxt;
  logic               arready_r;
  logic               arready_nxt;
  logic               rvalid_r;
  logic               rvalid_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic [1:0]         rresp_r;
  logic [1:0]         rresp_nxt;

  // data is captured at the edge the address is taken; upper bits read zero
  always_comb begin
    rdState_nxt = rdState_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    case (rdState_r)
      pwc_pkg::RD_IDLE: begin
        if (arvalid & arready_r) begin
          rdState_nxt = pwc_pkg::RD_DATA;
          arready_nxt = 1'b0;
          rvalid_nxt  = 1'b1;
          rresp_nxt   = `PWC_RESP_OKAY;
          case (regSel(araddr))
            pwc_pkg::REG_STATUS: rdata_nxt = {24'h000000, ctrl_r};
            pwc_pkg::REG_COUNT:  rdata_nxt = {24'h000000, cnt_r}; // [RQ10]
            pwc_pkg::REG_MODULO: rdata_nxt = {24'h000000, mod_r};
            default: begin
              rdata_nxt = 32'h00000000;
              rresp_nxt = `PWC_RESP_DECERR;
            end
          endcase
        end
      end
      pwc_pkg::RD_DATA: begin
        if (rready) begin
          rdState_nxt = pwc_pkg::RD_IDLE;
          arready_nxt = 1'b1;
          rvalid_nxt  = 1'b0;
        end
      end
      default: rdState_nxt = pwc_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdState_r <= pwc_pkg::RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `PWC_RESP_OKAY;
    end else begin
      rdState_r <= rdState_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, counter and register updates

  logic            srcEdge;
  pwc_pkg::ratio_t ratio;
  logic            psEvent;
  logic            restart;
  logic            flagSet;
  logic            flagClr;
  logic            ctrlWr;
  logic            modWr;
  pwc_pkg::ctrl_s  wrCtrl;

  always_comb begin
    // selected source; high bit set picks the internal reference, else low bit picks low-power osc or external
    case (ctrl_r.src)
      `PWC_SRC_LPO: srcEdge = srcRise[0];          // [RQ4]
      `PWC_SRC_EXT: srcEdge = srcRise[1];
      default:      srcEdge = srcRise[2];
    endcase
    ratio   = divRatio(ctrl_r.src[0], ctrl_r.ps);  // [RQ7] [RQ8]
    // code zero stops everything, and debug halt freezes both counters
    psEvent = (ratio != 18'h00000) & srcEdge & ~debugHalt &
              (psCnt_r == ratio - 18'h00001);      // [RQ21] [RQ22]
    wrCtrl  = pwc_pkg::ctrl_s'(wrByte);
    ctrlWr  = doWrite & wrLane & (wrSel == pwc_pkg::REG_STATUS);
    modWr   = doWrite & wrLane & (wrSel == pwc_pkg::REG_MODULO); // count writes ignored [RQ10]
    // a restart drops any wrap landing in the same cycle: a new period begins
    restart = modWr |                                             // [RQ14]
              (ctrlWr & (wrCtrl.src != ctrl_r.src)) |             // [RQ5]
              (ctrlWr & (wrCtrl.ps != ctrl_r.ps));                // [RQ9]
    // match with modulo zero wraps on every event
    flagSet = psEvent & ~restart & (cnt_r == mod_r);  // [RQ1] [RQ13] [RQ20]
    flagClr = ctrlWr & wrCtrl.flag;                   // [RQ2]
  end

  always_comb begin
    ctrl_nxt  = ctrl_r;
    mod_nxt   = mod_r;
    cnt_nxt   = cnt_r;
    psCnt_nxt = psCnt_r;
    if (ctrlWr) begin
      ctrl_nxt.src = wrCtrl.src;
      ctrl_nxt.ie  = wrCtrl.ie;
      ctrl_nxt.ps  = wrCtrl.ps;
    end
    // set beats a clear arriving in the same cycle
    if (flagSet) ctrl_nxt.flag = 1'b1;
    else if (flagClr) ctrl_nxt.flag = 1'b0;
    if (modWr) mod_nxt = wrByte;
    if (restart) begin
      cnt_nxt   = `PWC_CNT_RESET;
      psCnt_nxt = `PWC_PS_RESET;
    end else if (ratio != 18'h00000 & srcEdge & ~debugHalt) begin
      psCnt_nxt = psEvent ? `PWC_PS_RESET : psCnt_r + 18'h00001;
      if (psEvent) begin
        cnt_nxt = (cnt_r == mod_r) ? `PWC_CNT_RESET : cnt_r + 8'h01; // [RQ12] [RQ19]
      end
    end
    irq_nxt = ctrl_nxt.flag & ctrl_nxt.ie;  // [RQ6] [RQ23]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r  <= `PWC_CTRL_RESET;           // [RQ3] [RQ21]
      cnt_r   <= `PWC_CNT_RESET;            // [RQ11]
      mod_r   <= `PWC_MOD_RESET;            // [RQ15]
      psCnt_r <= `PWC_PS_RESET;
      irq_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      cnt_r   <= cnt_nxt;
      mod_r   <= mod_nxt;
      psCnt_r <= psCnt_nxt;
      irq_r   <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign awready  = awready_r;
  assign wready   = wready_r;
  assign bvalid   = bvalid_r;
  assign bresp    = bresp_r;
  assign arready  = arready_r;
  assign rvalid   = rvalid_r;
  assign rdata    = rdata_r;
  assign rresp    = rresp_r;
  assign matchIrq = irq_r;

endmodule : periodic_wakeup_counter

// ---- test/pwc_chk.sv ----
// Purpose: port-level checker for the periodic wake-up counter
// Assumes: default 12-bit byte addresses, write address and data offered together
// Notes:   bound to the design's top module after endmodule
`timescale 1ns/1ps
`include "pwc_map.svh"
module pwc_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              matchIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers; a write is only judged when both channels go at one edge
  logic wrTake;
  logic awMapped;
  logic arMapped;
  assign wrTake   = awvalid && awready && wvalid && wready;
  assign awMapped = awaddr inside {`PWC_OFS_STATUS, `PWC_OFS_COUNT, `PWC_OFS_MODULO};
  assign arMapped = araddr inside {`PWC_OFS_STATUS, `PWC_OFS_COUNT, `PWC_OFS_MODULO};
  ////////////////////////////////////////////////////////////////////////////////
  AST_B_FOLLOWS: assert property (wrTake |=> bvalid)
    else $error("write response missing");
  AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_FOLLOWS: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  AST_R_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  AST_RD_DECERR: assert property (arvalid && arready && !arMapped |=>
    rresp == `PWC_RESP_DECERR && rdata == 32'h00000000) else $error("unmapped read accepted");
  AST_WR_DECERR: assert property (wrTake && !awMapped |=> bresp == `PWC_RESP_DECERR)
    else $error("unmapped write accepted");
  AST_WR_OKAY: assert property (wrTake && awMapped |=> bresp == `PWC_RESP_OKAY)
    else $error("mapped write refused");
  AST_IRQ_MASKED: assert property (wrTake && awaddr == `PWC_OFS_STATUS && wstrb[0] &&
    !wdata[`PWC_BIT_IE] |=> !matchIrq) else $error("request with enable cleared");
  AST_IRQ_HELD: assert property (matchIrq && !(wvalid && wready) |=> matchIrq)
    else $error("request dropped without a write");
  AST_BUSY: assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted before response");
  ////////////////////////////////////////////////////////////////////////////////
  COV_WRITE: cover property (wrTake);
  COV_UNMAPPED: cover property (arvalid && arready && !arMapped);
  COV_IRQ: cover property ($rose(matchIrq));
endmodule : pwc_chk
bind periodic_wakeup_counter pwc_chk #(.ADDR_W(ADDR_W)) chk (.clk(clk), .nrst(nrst),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .matchIrq(matchIrq));

// ---- test/tb_periodic_wakeup_counter.sv ----
// Purpose: directed register-level bench for the periodic wake-up counter
// Assumes: source pulses last 8 clk, well under clk/4 toggle rate
// Notes:   ratio 1000 path costs about 8000 cycles
`timescale 1ns/1ps
`include "pwc_map.svh"
module tb_periodic_wakeup_counter;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        srcHi = 1'b0;
  logic [1:0]  pick = 2'h0;
  logic        debugHalt = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [3:0]  strb = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid, matchIrq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          failCount = 0;
  int          checksDone = 0;
  int          cycles = 0;
  wire         low_power_osc_clk = srcHi && pick == 2'h0;
  wire         ext = srcHi && pick == 2'h1;
  wire         irc = srcHi && pick[1];
  localparam logic [11:0] S = `PWC_OFS_STATUS;
  localparam logic [11:0] C = `PWC_OFS_COUNT;
  localparam logic [11:0] M = `PWC_OFS_MODULO;
  localparam logic [1:0]  OK = `PWC_RESP_OKAY;
  localparam logic [1:0]  DE = `PWC_RESP_DECERR;
  ////////////////////////////////////////////////////////////////////////////////
  periodic_wakeup_counter DUT (.clk(clk), .nrst(nrst), .lowPowerOscClk(low_power_osc_clk),
    .externalRefClk(ext), .internalRefClk(irc), .debugHalt(debugHalt), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .matchIrq(matchIrq));
  // clock and hang guard; the ceiling leaves about 2.4 times the expected run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // write both channels together, drop each when taken, hold bready until answered
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check(rdata, {24'h000000, d});
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd
  // each pulse is 4 clk high, 4 low, so the synchroniser never misses an edge
  task automatic pulse(input int n);
    repeat (n) begin
      srcHi <= 1'b1;
      repeat (4) @(posedge clk);
      srcHi <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : pulse
  task automatic irq(input logic e);
    #1;
    check({31'h0, matchIrq}, {31'h0, e});
  endtask : irq
  task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: status byte is flag, source[1:0], enable, divider[3:0]
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(S, 8'h00, OK);
    rd(C, 8'h00, OK);
    rd(M, 8'h00, OK);
    rd(12'h00c, 8'h00, DE);
    wr(12'h010, 8'hff, DE);
    pulse(2);
    rd(C, 8'h00, OK);
    wr(M, 8'h03, OK);
    wr(S, 8'h18, OK);
    pulse(3);
    rd(C, 8'h03, OK);
    irq(1'b0);
    pulse(1);
    rd(C, 8'h00, OK);
    rd(S, 8'h98, OK);
    irq(1'b1);
    pulse(2);
    wr(C, 8'h55, OK);
    rd(C, 8'h02, OK);
    wr(S, 8'h18, OK);
    rd(S, 8'h98, OK);
    rd(C, 8'h02, OK);
    wr(S, 8'h98, OK);
    rd(S, 8'h18, OK);
    irq(1'b0);
    wr(S, 8'h19, OK);
    rd(C, 8'h00, OK);
    pulse(2);
    rd(C, 8'h01, OK);
    debugHalt <= 1'b1;
    pulse(4);
    rd(C, 8'h01, OK);
    debugHalt <= 1'b0;
    pulse(2);
    rd(C, 8'h02, OK);
    wr(M, 8'h00, OK);
    rd(C, 8'h00, OK);
    pulse(2);
    rd(S, 8'h99, OK);
    wr(S, 8'h99, OK);
    rd(S, 8'h19, OK);
    pulse(2);
    rd(S, 8'h99, OK);
    wr(M, 8'h05, OK);
    wr(S, 8'h28, OK);
    irq(1'b0);
    pick <= 2'h1; // source toggles before counting is relied on
    pulse(999);
    rd(C, 8'h00, OK);
    pulse(1);
    rd(C, 8'h01, OK);
    wr(S, 8'h48, OK);
    rd(C, 8'h00, OK);
    pulse(1);
    rd(C, 8'h00, OK);
    pick <= 2'h2;
    pulse(1);
    rd(C, 8'h01, OK);
    // a write with lane 0 disabled must neither land nor restart the counters
    strb <= 4'h0;
    wr(M, 8'h77, OK);
    strb <= 4'h1;
    rd(M, 8'h05, OK);
    rd(C, 8'h01, OK);
    // mid-run reset with flag, source, divider and modulo all non-zero
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(M, 8'h00, OK);
    rd(S, 8'h00, OK);
    rd(C, 8'h00, OK);
    irq(1'b0);
    summarize();
  end
endmodule : tb_periodic_wakeup_counter
